// >>> core/tsp_pkg.sv
// package: register map, field positions, reset values and timing for the shared-prescaler timer
package tsp_pkg;
    // register byte addresses on the apb bus
    localparam logic [11:0] TSP_ADDR_CONFIG = 12'h000;
    localparam logic [11:0] TSP_ADDR_COUNT = 12'h004;
    localparam logic [11:0] TSP_ADDR_IRQ_CTRL = 12'h008;
    localparam logic [11:0] TSP_ADDR_STATUS = 12'h00C;
    localparam logic [11:0] TSP_ADDR_CLEAR = 12'h010;
    localparam logic [11:0] TSP_ADDR_ENABLE = 12'h014;
    localparam logic [11:0] TSP_ADDR_CONTROL = 12'h018;
    // timer_config fields
    localparam int TSP_CFG_SRC = 5;
    localparam int TSP_CFG_EDGE = 4;
    localparam int TSP_CFG_ASSIGN = 3;
    localparam int TSP_CFG_RATE_LO = 0;
    localparam logic [7:0] TSP_CFG_RESET = 8'hFF;
    // interrupt_control fields
    localparam int TSP_IC_FLAG = 2;
    localparam int TSP_IC_ENABLE = 5;
    // status / clear / enable layout
    localparam int TSP_ST_OVF = 0;
    localparam int TSP_ST_WDT_PULSE = 1;
    // control register fields
    localparam int TSP_CTL_SLEEP = 0;
    localparam int TSP_CTL_WDT_CLEAR = 1;
    // instruction cycle: four sys clocks per cycle (phase one to four)
    localparam int TSP_PHASES = 4;
    localparam logic [1:0] TSP_PHASE_TWO = 2'h1;
    localparam logic [1:0] TSP_PHASE_FOUR = 2'h3;
    // increments suppressed after a count write, in instruction cycles
    localparam logic [1:0] TSP_WRITE_HOLD = 2'h2;
    // apb reads of unmapped space
    localparam logic [31:0] TSP_UNMAPPED = 32'h0000_0000;
endpackage : tsp_pkg

// >>> core/tsp_edge_sync.sv
// external count pin synchroniser with edge select
`timescale 1ns/1ps
module tsp_edge_sync
    import tsp_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // pin and selection
    input wire logic pin_in,
    input wire logic falling_in,
    // one-cycle event
    output logic edge_out
);
    logic [2:0] sync;
    logic stable;
    logic stable_prev;
    logic next_stable;

    // three flops; a change counts once stages two and three agree
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            sync <= 3'h0;
        end else begin
            sync <= {sync[1:0], pin_in};
        end
    end

    always_comb begin
        next_stable = stable;
        if (sync[1] == sync[2]) begin
            next_stable = sync[2];
        end
    end

    // edge is qualified by the selected polarity
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            stable <= 1'b0;
            stable_prev <= 1'b0;
            edge_out <= 1'b0;
        end else begin
            stable <= next_stable;
            stable_prev <= stable;
            edge_out <= falling_in ? (stable_prev & ~stable) : (~stable_prev & stable);
        end
    end
endmodule : tsp_edge_sync

// >>> core/tsp_prescaler.sv
// shared 8-bit prescaler, assignable to timer or watchdog
`timescale 1ns/1ps
module tsp_prescaler
    import tsp_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // control
    input wire logic tick_in,
    input wire logic clear_in,
    input wire logic [2:0] rate_in,
    input wire logic to_watchdog_in,
    // divided event
    output logic pulse_out
);
    logic [7:0] count;
    logic [7:0] next_count;
    logic [7:0] limit;

    // terminal count: timer 2^(rate+1), watchdog 2^rate
    function automatic logic [7:0] ratio_limit(input logic [2:0] rate, input logic wdt);
        logic [8:0] ratio;
        ratio = wdt ? (9'h001 << rate) : (9'h002 << rate);
        ratio_limit = ratio[7:0] - 8'h01;
        if (ratio[8]) begin
            ratio_limit = 8'hFF;
        end
    endfunction : ratio_limit

    assign limit = ratio_limit(rate_in, to_watchdog_in);
    assign next_count = (count >= limit) ? 8'h00 : count + 8'h01;

    // count never visible to software; only cleared
    always_ff @(posedge sys_clk_in) begin
        if (reset_in || clear_in) begin
            count <= 8'h00;
            pulse_out <= 1'b0;
        end else begin
            pulse_out <= tick_in && (count >= limit);
            if (tick_in) begin
                count <= next_count;
            end
        end
    end
endmodule : tsp_prescaler

// >>> core/tsp_timer.sv
// 8-bit timer/counter with shared prescaler, apb slave and overflow interrupt
//
// Summary of operation
// - one prescaler, timer or watchdog, assign bit
// - timer rates 1:2 up to 1:256
// - watchdog assigned: timer 1:1, wdt 1:1-1:128
// - prescaler hidden; count writes clear it when on timer
// - watchdog clear also clears assigned prescaler
// - overflow flag sets on every FFh to 00h
// - flag sticky until software; enable gates request
// - count frozen during sleep, no wake
// - external events sampled on phases two, four
// - source bit: instruction clock or pin
// - edge bit: set falling, clear rising
// - config fully read/write, resets to all ones
// - undivided timer advances once per instruction
// - two instruction cycles no increment after write
`timescale 1ns/1ps
module tsp_timer
    import tsp_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // external count pin
    input wire logic ext_count_input_in,
    // watchdog side
    output logic watchdog_tick_out,
    output logic watchdog_clear_out,
    // interrupt
    output logic irq_out
);
    logic [7:0] timer_config;
    logic [7:0] count_register;
    logic overflow_flag;
    logic overflow_irq_enable;
    logic [1:0] irq_status;
    logic [1:0] irq_enable;
    logic sleep_mode;
    logic [1:0] phase;
    logic [1:0] hold;
    logic ext_edge;
    logic ext_pending;
    logic src_event;
    logic pre_pulse;
    logic pre_clear;
    logic count_write;
    logic wdt_clear;
    logic inc;
    logic wrap;
    logic instr_tick;
    logic access;
    logic wr;
    logic prescaler_assign;
    logic [2:0] prescale_rate_sel;
    logic count_source_sel;
    logic count_edge_sel;
    logic instr_late;
    logic cfg_write;
    logic irq_ctrl_write;
    logic clear_write;
    logic enable_write;
    logic control_write;

    // register map, one aligned word each, 8-bit fields in bits 7:0
    //   0x00 timer_config       all bits read/write
    //   0x04 timer_count        write also restarts hold, and prescaler when on timer
    //   0x08 interrupt_control  bit 5 enable, bit 2 overflow flag
    //   0x0c status             read-only sticky events
    //   0x10 clear              write-one-to-clear, reads zero
    //   0x14 enable             status interrupt enables
    //   0x18 control            bit 0 sleep level, bit 1 watchdog clear
    //   status, clear and enable: bit 0 overflow, bit 1 watchdog event
    // interrupt: flag with its enable, or status with enable register
    // anything else answers with an error and ignores writes

    // completed write to one register; the access edge is the commit point
    function automatic logic write_hit(input logic w, input logic [11:0] a,
        input logic [11:0] target);
        write_hit = w && (a == target);
    endfunction : write_hit

    assign prescaler_assign = timer_config[TSP_CFG_ASSIGN];
    assign prescale_rate_sel = timer_config[TSP_CFG_RATE_LO +: 3];
    assign count_source_sel = timer_config[TSP_CFG_SRC];
    assign count_edge_sel = timer_config[TSP_CFG_EDGE];
    assign access = psel_in && penable_in;
    assign wr = access && pwrite_in;
    // per-register write strobes
    assign count_write = write_hit(wr, paddr_in, TSP_ADDR_COUNT);
    assign cfg_write = write_hit(wr, paddr_in, TSP_ADDR_CONFIG);
    assign irq_ctrl_write = write_hit(wr, paddr_in, TSP_ADDR_IRQ_CTRL);
    assign clear_write = write_hit(wr, paddr_in, TSP_ADDR_CLEAR);
    assign enable_write = write_hit(wr, paddr_in, TSP_ADDR_ENABLE);
    assign control_write = write_hit(wr, paddr_in, TSP_ADDR_CONTROL);
    assign wdt_clear = control_write && pwdata_in[TSP_CTL_WDT_CLEAR];
    assign instr_tick = (phase == TSP_PHASE_FOUR);

    // instruction cycle phase counter, frozen during sleep
    // phase 3 is the instruction tick; pin samples at phases 1 and 3
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            phase <= 2'h0;
        end else if (!sleep_mode) begin
            phase <= phase + 2'h1;
        end
    end

    // edge select is live; changing it may count one stray edge
    tsp_edge_sync u_edge (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .pin_in(ext_count_input_in),
        .falling_in(count_edge_sel),
        .edge_out(ext_edge)
    );

    // pin edges held until the next phase two or four sample
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            ext_pending <= 1'b0;
        end else if (phase == TSP_PHASE_TWO || phase == TSP_PHASE_FOUR) begin
            ext_pending <= ext_edge;
        end else if (ext_edge) begin
            ext_pending <= 1'b1;
        end
    end

    // source event: instruction clock or sampled pin edge
    always_comb begin
        src_event = 1'b0;
        if (!sleep_mode) begin
            if (count_source_sel) begin
                src_event = ext_pending && (phase == TSP_PHASE_TWO || phase == TSP_PHASE_FOUR);
            end else begin
                src_event = instr_tick;
            end
        end
    end

    // prescaler clears: count write when on timer, wdt clear when on watchdog
    assign pre_clear = (count_write && !prescaler_assign) ||
        (wdt_clear && prescaler_assign);

    tsp_prescaler u_pre (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .tick_in(prescaler_assign ? instr_tick && !sleep_mode : src_event),
        .clear_in(pre_clear),
        .rate_in(prescale_rate_sel),
        .to_watchdog_in(prescaler_assign),
        .pulse_out(pre_pulse)
    );

    // timer increments on prescaler pulse, or undivided source when on watchdog
    assign inc = (prescaler_assign ? src_event : pre_pulse) && (hold == 2'h0) && !sleep_mode;
    assign wrap = inc && (count_register == 8'hFF);

    // post-write hold, counted in instruction cycles
    // counts ticks, not clocks, so it stays aligned to the phases
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            hold <= 2'h0;
        end else if (count_write) begin
            hold <= TSP_WRITE_HOLD;
        end else if (instr_tick && hold != 2'h0) begin
            hold <= hold - 2'h1;
        end
    end

    // count register; software write wins over an increment
    // increments due while asleep are lost, not deferred
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            count_register <= 8'h00;
        end else if (count_write) begin
            count_register <= pwdata_in[7:0];
        end else if (inc) begin
            count_register <= count_register + 8'h01;
        end
    end

    // configuration, all bits read/write, reset to ones
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            timer_config <= TSP_CFG_RESET;
        end else if (cfg_write) begin
            timer_config <= pwdata_in[7:0];
        end
    end

    // instruction tick delayed one clock, so the undivided watchdog event
    // leaves on the same clock as a prescaler pulse; switching the
    // assignment then never squeezes two events closer together
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            instr_late <= 1'b0;
        end else begin
            instr_late <= instr_tick && !sleep_mode;
        end
    end

    // control: sleep level; wdt clear is write-only strobe
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            sleep_mode <= 1'b0;
            watchdog_clear_out <= 1'b0;
            watchdog_tick_out <= 1'b0;
        end else begin
            if (control_write) begin
                sleep_mode <= pwdata_in[TSP_CTL_SLEEP];
            end
            watchdog_clear_out <= wdt_clear;
            watchdog_tick_out <= prescaler_assign ? pre_pulse : instr_late;
        end
    end

    // overflow flag in interrupt_control; set beats software clear
    // a write of zero in the wrap cycle loses to the set
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            overflow_flag <= 1'b0;
            overflow_irq_enable <= 1'b0;
        end else begin
            if (irq_ctrl_write) begin
                overflow_irq_enable <= pwdata_in[TSP_IC_ENABLE];
                overflow_flag <= pwdata_in[TSP_IC_FLAG];
            end
            if (wrap) begin
                overflow_flag <= 1'b1;
            end
        end
    end

    // sticky status bits, write-one clear, set has priority
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            irq_status <= 2'h0;
            irq_enable <= 2'h0;
        end else begin
            if (enable_write) begin
                irq_enable <= pwdata_in[1:0];
            end
            irq_status <= (irq_status & ~(clear_write ? pwdata_in[1:0] : 2'h0))
                | {watchdog_tick_out, wrap};
        end
    end

    // interrupt: legacy enable gates the flag, status path gated by enable register
    // registered, so it trails the flag by one clock
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= (overflow_flag && overflow_irq_enable) || |(irq_status & irq_enable);
        end
    end

    // apb: zero wait states, unmapped reads zero with error
    // read data is muxed at the setup edge so it stands through access
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            prdata_out <= TSP_UNMAPPED;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out <= psel_in && !penable_in;
            pslverr_out <= 1'b0;
            prdata_out <= TSP_UNMAPPED;
            if (psel_in && !penable_in) begin
                if (paddr_in == TSP_ADDR_CONFIG) begin
                    prdata_out <= {24'h00_0000, timer_config};
                end else if (paddr_in == TSP_ADDR_COUNT) begin
                    prdata_out <= {24'h00_0000, count_register};
                end else if (paddr_in == TSP_ADDR_IRQ_CTRL) begin
                    prdata_out <= {26'h000_0000, overflow_irq_enable, 2'h0, overflow_flag, 2'h0};
                end else if (paddr_in == TSP_ADDR_STATUS) begin
                    prdata_out <= {30'h0000_0000, irq_status};
                end else if (paddr_in == TSP_ADDR_ENABLE) begin
                    prdata_out <= {30'h0000_0000, irq_enable};
                end else if (paddr_in == TSP_ADDR_CONTROL) begin
                    prdata_out <= {31'h0000_0000, sleep_mode};
                end else if (paddr_in != TSP_ADDR_CLEAR) begin
                    pslverr_out <= 1'b1;
                end
            end
        end
    end
endmodule : tsp_timer

// >>> bench/tsp_timer_props.sv
// port-level checks for the shared-prescaler timer
`timescale 1ns/1ps
module tsp_timer_props
    import tsp_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // pin, watchdog and interrupt
    input wire logic ext_count_input_in,
    input wire logic watchdog_tick_out,
    input wire logic watchdog_clear_out,
    input wire logic irq_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    // completed control write carrying the watchdog clear bit
    logic wd_wr;
    assign wd_wr = psel_in && penable_in && pwrite_in && pready_out
        && paddr_in == TSP_ADDR_CONTROL && pwdata_in[TSP_CTL_WDT_CLEAR];
    a_ready_follows: assert property (psel_in && !penable_in |=> pready_out)
        else $error("no answer after setup");
    a_ready_framed: assert property (pready_out |-> psel_in && penable_in)
        else $error("answer outside access");
    a_error_decode: assert property (pready_out && paddr_in[1:0] == 2'h0
        |-> pslverr_out == (paddr_in > TSP_ADDR_CONTROL)) else $error("bad decode");
    a_read_upper: assert property (pready_out && !pwrite_in
        |-> prdata_out[31:8] == 24'h00_0000) else $error("upper read bits set");
    a_clear_reads: assert property (pready_out && !pwrite_in
        && paddr_in == TSP_ADDR_CLEAR |-> prdata_out == 32'h0000_0000 && !pslverr_out)
        else $error("clear register not zero");
    a_wdclr_pulse: assert property (wd_wr |=> watchdog_clear_out)
        else $error("watchdog clear missing");
    a_wdclr_cause: assert property (watchdog_clear_out |-> $past(wd_wr))
        else $error("watchdog clear without write");
    a_tick_spacing: assert property (watchdog_tick_out |=> !watchdog_tick_out [*3])
        else $error("watchdog ticks too close");
endmodule : tsp_timer_props

// >>> bench/tb.sv
// self-checking bench for the shared-prescaler timer
`timescale 1ns/1ps
module tb
    import tsp_pkg::*;
;
    logic sys_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0000_0000;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    logic pin = 1'b0;
    logic irq_out;
    logic wd_clr;
    logic [31:0] rd;
    logic [31:0] r0;
    logic err;
    int errors = 0;
    int checks_done = 0;
    always #10 sys_clk_in = ~sys_clk_in;
    tsp_timer i_dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .ext_count_input_in(pin), .watchdog_tick_out(),
        .watchdog_clear_out(wd_clr), .irq_out(irq_out));
    // one apb transfer, held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge sys_clk_in);
        penable_in <= 1'b1;
        @(posedge sys_clk_in);
        while (pready_out !== 1'b1) @(posedge sys_clk_in);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask : cyc
    task automatic t_regs;
        apb(1'b0, TSP_ADDR_CONFIG, 32'h0);
        chk("config reset", 32'h0000_00FF, rd);
        apb(1'b1, TSP_ADDR_CONFIG, 32'h0000_005A);
        apb(1'b1, 12'h01C, 32'h0000_0011);
        chk("unmapped err", 32'h1, {31'h0, err});
        apb(1'b0, TSP_ADDR_CONFIG, 32'h0);
        chk("config rw", 32'h0000_005A, rd);
        apb(1'b0, TSP_ADDR_CLEAR, 32'h0);
        chk("clear reads", 32'h0, rd);
        apb(1'b1, TSP_ADDR_CONTROL, 32'h0000_0002);
        cyc(1);
        chk("wdt clear pulse", 32'h1, {31'h0, wd_clr});
        $display("test regs done");
    endtask : t_regs
    // span between samples is a whole number of increment periods
    task automatic rate_chk(input logic [7:0] cfg, input int per);
        apb(1'b1, TSP_ADDR_CONFIG, {24'h00_0000, cfg});
        cyc(per);
        apb(1'b0, TSP_ADDR_COUNT, 32'h0);
        r0 = rd;
        cyc(per * 4 - 3);
        apb(1'b0, TSP_ADDR_COUNT, 32'h0);
        chk("count advance", 32'h4, (rd - r0) & 32'h0000_00FF);
    endtask : rate_chk
    task automatic t_rates;
        for (int r = 0; r < 8; r++) begin
            rate_chk(8'(r), 8 << r);
        end
        rate_chk(8'h0F, 4);
        $display("test rates done");
    endtask : t_rates
    // pulses end high, so rising mode sees one edge more than falling
    task automatic pin_chk(input logic [7:0] cfg, input logic [7:0] n);
        pin <= 1'b0;
        cyc(8);
        apb(1'b1, TSP_ADDR_CONFIG, {24'h00_0000, cfg});
        apb(1'b1, TSP_ADDR_COUNT, 32'h0);
        cyc(16);
        repeat (5) begin
            pin <= 1'b1;
            cyc(12);
            pin <= 1'b0;
            cyc(12);
        end
        pin <= 1'b1;
        cyc(16);
        apb(1'b0, TSP_ADDR_COUNT, 32'h0);
        chk("pin count", {24'h00_0000, n}, rd);
    endtask : pin_chk
    task automatic t_pin;
        pin_chk(8'h28, 8'h06);
        pin_chk(8'h38, 8'h05);
        $display("test pin done");
    endtask : t_pin
    // prescaler moved both ways with the prescribed software sequences
    task automatic t_move;
        apb(1'b1, TSP_ADDR_CONFIG, 32'h0000_0000);
        apb(1'b1, TSP_ADDR_CONTROL, 32'h0000_0002);
        apb(1'b1, TSP_ADDR_COUNT, 32'h0);
        apb(1'b1, TSP_ADDR_CONFIG, 32'h0000_0008);
        apb(1'b1, TSP_ADDR_CONTROL, 32'h0000_0002);
        apb(1'b1, TSP_ADDR_CONFIG, 32'h0000_000D);
        apb(1'b0, TSP_ADDR_CONFIG, 32'h0);
        chk("to watchdog", 32'h0000_000D, rd);
        apb(1'b1, TSP_ADDR_CONTROL, 32'h0000_0002);
        apb(1'b1, TSP_ADDR_CONFIG, 32'h0000_0003);
        rate_chk(8'h03, 64);
        $display("test move done");
    endtask : t_move
    task automatic t_ovf;
        apb(1'b1, TSP_ADDR_CONFIG, 32'h0000_0008);
        apb(1'b1, TSP_ADDR_COUNT, 32'h0000_00FE);
        apb(1'b0, TSP_ADDR_COUNT, 32'h0);
        apb(1'b0, TSP_ADDR_COUNT, 32'h0);
        chk("write hold", 32'h0000_00FE, rd);
        cyc(20);
        apb(1'b1, TSP_ADDR_CONTROL, 32'h0000_0001);
        apb(1'b0, TSP_ADDR_COUNT, 32'h0);
        r0 = rd;
        cyc(40);
        apb(1'b0, TSP_ADDR_COUNT, 32'h0);
        chk("sleep hold", r0, rd);
        apb(1'b0, TSP_ADDR_IRQ_CTRL, 32'h0);
        chk("flag sticky", 32'h0000_0004, rd);
        chk("irq masked", 32'h0, {31'h0, irq_out});
        apb(1'b0, TSP_ADDR_STATUS, 32'h0);
        chk("status ovf", 32'h1, rd & 32'h0000_0001);
        apb(1'b1, TSP_ADDR_ENABLE, 32'h0000_0001);
        cyc(2);
        chk("irq status", 32'h1, {31'h0, irq_out});
        apb(1'b1, TSP_ADDR_CLEAR, 32'h0000_0001);
        cyc(2);
        chk("irq cleared", 32'h0, {31'h0, irq_out});
        apb(1'b1, TSP_ADDR_ENABLE, 32'h0);
        apb(1'b1, TSP_ADDR_IRQ_CTRL, 32'h0000_0024);
        cyc(2);
        chk("irq flag", 32'h1, {31'h0, irq_out});
        apb(1'b1, TSP_ADDR_IRQ_CTRL, 32'h0);
        apb(1'b0, TSP_ADDR_IRQ_CTRL, 32'h0);
        chk("flag cleared", 32'h0, rd);
        apb(1'b1, TSP_ADDR_CONTROL, 32'h0);
        $display("test overflow done");
    endtask : t_ovf
    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done
    // main sequence after the reset hold
    initial begin
        repeat (12) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        t_regs();
        t_rates();
        t_pin();
        t_move();
        t_ovf();
        test_done();
    end
    // hang guard, well past the expected run length
    initial begin
        repeat (40000) @(posedge sys_clk_in);
        errors++;
        test_done();
    end
endmodule : tb
bind tsp_timer tsp_timer_props i_props (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .ext_count_input_in(ext_count_input_in), .watchdog_tick_out(watchdog_tick_out),
    .watchdog_clear_out(watchdog_clear_out), .irq_out(irq_out));
